// file: core/cfgseq_regs.svh
`ifndef CFGSEQ_REGS_SVH
`define CFGSEQ_REGS_SVH
// ----------------------------------------------------------------------------
// Register map (APB byte addresses)
// ----------------------------------------------------------------------------
`define CFGSEQ_CTRL_ADDR 12'h000
`define CFGSEQ_PHASE_ADDR 12'h004
`define CFGSEQ_CMD_ADDR 12'h008
`define CFGSEQ_STAT_ADDR 12'h00c
`define CFGSEQ_DEBUG_ADDR 12'h010
`define CFGSEQ_RATE_ADDR 12'h014
// ----------------------------------------------------------------------------
// CTRL fields
// ----------------------------------------------------------------------------
`define CFGSEQ_CTRL_PIPE 0
`define CFGSEQ_CTRL_DRIVE 1
`define CFGSEQ_CTRL_PERSIST 2
`define CFGSEQ_CTRL_SHUTRST 3
`define CFGSEQ_CTRL_SEC_LO 4
`define CFGSEQ_CTRL_CLKSEL_LO 6
`define CFGSEQ_CTRL_KEY 8
`define CFGSEQ_CTRL_CHAIN_LO 9
`define CFGSEQ_CTRL_DEBUG 11
`define CFGSEQ_CTRL_START 12
// ----------------------------------------------------------------------------
// PHASE fields, 4 bits each: 0..6 phase, 7 nowait, 8 done, 9 keep
// ----------------------------------------------------------------------------
`define CFGSEQ_PH_DONE_LO 0
`define CFGSEQ_PH_TRI_LO 4
`define CFGSEQ_PH_WE_LO 8
`define CFGSEQ_PH_LOCK_LO 12
`define CFGSEQ_PH_MATCH_LO 16
`define CFGSEQ_SEL_NOWAIT 4'h7
`define CFGSEQ_SEL_DONE 4'h8
`define CFGSEQ_SEL_KEEP 4'h9
`define CFGSEQ_PHASE_RST 32'h00077654
`define CFGSEQ_RATE_MIN 6'h04
`define CFGSEQ_RATE_MAX 6'h3c
`define CFGSEQ_LAST_PHASE 3'h6
`define CFGSEQ_DEBUG_ZERO_BITS 32
// ----------------------------------------------------------------------------
// CMD bits (write one to pulse)
// ----------------------------------------------------------------------------
`define CFGSEQ_CMD_SHUTDOWN 0
`define CFGSEQ_CMD_GHIGH 1
`define CFGSEQ_CMD_RECONFIG 2
`define CFGSEQ_CMD_FRAME 3
`define CFGSEQ_CMD_CRC 4
`define CFGSEQ_CMD_MULTI 5
`define CFGSEQ_CMD_SYNC 6
`endif

// file: core/cfgseq_pkg.sv
package cfgseq_pkg;
    typedef enum logic [1:0] {CFGSEQ_CLK_CFG, CFGSEQ_CLK_USER, CFGSEQ_CLK_TEST} cfgseq_clksel_t;
    typedef enum logic [1:0] {CFGSEQ_SEC_NONE, CFGSEQ_SEC_L1, CFGSEQ_SEC_L2} cfgseq_sec_t;
    typedef enum logic [1:0] {
        CFGSEQ_KEY_SINGLE, CFGSEQ_KEY_FIRST, CFGSEQ_KEY_MIDDLE, CFGSEQ_KEY_LAST
    } cfgseq_chain_t;
    typedef struct packed {
        logic globalWriteEnable;
        logic blockMemoryEnable;
        logic globalTristateHold;
        logic doneDrive;
        logic doneOe;
    } cfgseq_out_t;
endpackage : cfgseq_pkg

// file: core/cfgseq_top.sv
`timescale 1ns/1ps
`include "cfgseq_regs.svh"
// Contract
// - Completion asserts in selectable phase 1..6, default 4.
// - Pipelined completion waits for pin high, then one more startup edge.
// - Active drive option drives completion pin high; default pull-up only.
// - Tri-state hold released in phase 1..6, on done, or kept; default 5.
// - Done-based release uses qualified completion, delayed when pipelined.
// - Write enable and block memory enable in phase 1..6, default 6.
// - Write enable may follow qualified completion, or keep its value.
// - Stall in phase 0..6 until clock managers lock; default no wait.
// - Stall in phase 0..6 until impedance match; default no wait.
// - Startup clock selectable: config clock, user clock, test-port clock.
// - Master config clock rate settable 4..60, default 4.
// - Optional clock-manager reset after shutdown and global-high commands.
// - Level 1 blocks readback; level 2 also flags partial reconfiguration commands as errors, yet they still restart startup.
// - Retention keeps parallel config port pins dedicated after startup.
// - Debug stream: each frame CRC checked, frame address logged.
// - Multiple-frame write of one frame to several addresses supported.
// - Starting key index 0 or 3, default 0, with chain position.
// - Test-port clock choice advances on the test access port clock.
// - User clock choice advances on user clock input.
module cfgseq_top import cfgseq_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Startup clock sources, sampled as levels
    input wire logic cfgClkTick,
    input wire logic userClock,
    input wire logic testPortClock,
    // Status from the fabric and the completion pin
    input wire logic clockManagerLocked,
    input wire logic impedanceMatched,
    input wire logic donePinIn,
    // Startup outputs
    output logic globalWriteEnable,
    output logic blockMemoryEnable,
    output logic globalTristateHold,
    output logic donePinOut,
    output logic donePinOe,
    output logic clockManagerReset,
    output logic configPortDedicated,
    output logic readbackAllowed,
    output logic partialReconfigAllowed,
    output logic [5:0] configClockRate
);
    // ------------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------------
    logic [12:0] ctrl_q, ctrl_d;
    logic [19:0] phase_q, phase_d;
    logic [5:0] rate_q, rate_d;
    logic [31:0] debug_q, debug_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d, pslverr_q, pslverr_d;
    logic shutSeen_q, shutSeen_d, ghighSeen_q, ghighSeen_d, cmReset_q, cmReset_d;
    logic crcPending_q, crcPending_d;
    logic [7:0] multiCount_q, multiCount_d;
    logic reconfig;
    // Pin-facing copies get flip-flops of their own, so that no output passes through a gate.
    logic holdOut_q, holdOut_d, doneOe_q, doneOe_d, rbAllow_q, rbAllow_d, prAllow_q, prAllow_d;
    logic wrStb;
    logic rdStb;
    assign wrStb = psel && penable && pwrite && !pready_q;
    assign rdStb = psel && penable && !pwrite && !pready_q;
    assign reconfig = wrStb && paddr == `CFGSEQ_CMD_ADDR && pwdata[`CFGSEQ_CMD_RECONFIG];

    // ------------------------------------------------------------------------
    // Startup sequencer state
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cfgseq_state_t;
    cfgseq_state_t state_q, state_d;
    logic [2:0] ph_q, ph_d;
    logic [2:0] clkSync_q, clkSync_d;
    logic pinDelay_q, pinDelay_d;
    logic doneAct_q, doneAct_d, tri_q, tri_d, gwe_q, gwe_d;
    logic stepClk, stepEdge, stall, qualDone, secBlocked;
    logic [3:0] selDone, selTri, selWe, selLock, selMatch;
    cfgseq_clksel_t clkSel;

    assign selDone = phase_q[`CFGSEQ_PH_DONE_LO +: 4];
    assign selTri = phase_q[`CFGSEQ_PH_TRI_LO +: 4];
    assign selWe = phase_q[`CFGSEQ_PH_WE_LO +: 4];
    assign selLock = phase_q[`CFGSEQ_PH_LOCK_LO +: 4];
    assign selMatch = phase_q[`CFGSEQ_PH_MATCH_LO +: 4];
    assign clkSel = cfgseq_clksel_t'(ctrl_q[`CFGSEQ_CTRL_CLKSEL_LO +: 2]);

    always_comb begin
        case (clkSel)
            CFGSEQ_CLK_USER: stepClk = userClock;
            CFGSEQ_CLK_TEST: stepClk = testPortClock;
            default: stepClk = cfgClkTick;
        endcase
    end
    // Edges of the selected startup clock are detected from a sampled copy.
    assign stepEdge = clkSync_q[1] && !clkSync_q[2];
    assign stall = (selLock == {1'b0, ph_q} && !clockManagerLocked)
        || (selMatch == {1'b0, ph_q} && !impedanceMatched);
    assign qualDone = ctrl_q[`CFGSEQ_CTRL_PIPE] ? pinDelay_q : donePinIn;

    always_comb begin
        state_d = state_q;
        ph_d = ph_q;
        clkSync_d = {clkSync_q[1:0], stepClk};
        pinDelay_d = pinDelay_q;
        doneAct_d = doneAct_q;
        tri_d = tri_q;
        gwe_d = gwe_q;
        if (stepEdge && donePinIn) begin
            pinDelay_d = 1'b1;
        end
        case (state_q)
            ST_IDLE: begin
                if (ctrl_q[`CFGSEQ_CTRL_START]) begin
                    state_d = ST_RUN;
                    ph_d = 3'h0;
                end
            end
            ST_RUN: begin
                if (stepEdge && !stall) begin
                    if (ph_q != `CFGSEQ_LAST_PHASE) begin
                        ph_d = ph_q + 3'h1;
                        if (selDone == {1'b0, ph_d}) doneAct_d = 1'b1;
                        if (selTri == {1'b0, ph_d}) tri_d = 1'b1;
                        if (selWe == {1'b0, ph_d}) gwe_d = 1'b1;
                    end else if (!ctrl_q[`CFGSEQ_CTRL_PIPE] || pinDelay_q) begin
                        state_d = ST_DONE;
                    end
                end
            end
            ST_DONE: ;
            default: state_d = ST_IDLE;
        endcase
        if (selTri == `CFGSEQ_SEL_DONE && qualDone && state_q != ST_IDLE) tri_d = 1'b1;
        if (selWe == `CFGSEQ_SEL_DONE && qualDone && state_q != ST_IDLE) gwe_d = 1'b1;
        // Keep setting never sets the write enable; a restart still clears it.
        if (reconfig || cmReset_q) begin
            state_d = ST_IDLE;
            ph_d = 3'h0;
            doneAct_d = 1'b0;
            tri_d = 1'b0;
            gwe_d = 1'b0;
            pinDelay_d = 1'b0;
        end
        holdOut_d = !tri_d;
        doneOe_d = doneAct_d && ctrl_d[`CFGSEQ_CTRL_DRIVE];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            ph_q <= 3'h0;
            clkSync_q <= 3'h0;
            pinDelay_q <= 1'b0;
            doneAct_q <= 1'b0;
            tri_q <= 1'b0;
            gwe_q <= 1'b0;
            holdOut_q <= 1'b1;
            doneOe_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ph_q <= ph_d;
            clkSync_q <= clkSync_d;
            pinDelay_q <= pinDelay_d;
            doneAct_q <= doneAct_d;
            tri_q <= tri_d;
            gwe_q <= gwe_d;
            holdOut_q <= holdOut_d;
            doneOe_q <= doneOe_d;
        end
    end

    // ------------------------------------------------------------------------
    // APB register file and configuration commands
    // ------------------------------------------------------------------------
    assign secBlocked = cfgseq_sec_t'(ctrl_q[`CFGSEQ_CTRL_SEC_LO +: 2]) != CFGSEQ_SEC_NONE;

    always_comb begin
        ctrl_d = ctrl_q;
        phase_d = phase_q;
        rate_d = rate_q;
        debug_d = debug_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        shutSeen_d = shutSeen_q;
        ghighSeen_d = ghighSeen_q;
        crcPending_d = crcPending_q;
        multiCount_d = multiCount_q;
        cmReset_d = 1'b0;
        // The clear comes first, so a command written in the same cycle still sets its flag.
        if (ctrl_q[`CFGSEQ_CTRL_SHUTRST] && shutSeen_q && ghighSeen_q) begin
            cmReset_d = 1'b1;
            shutSeen_d = 1'b0;
            ghighSeen_d = 1'b0;
        end
        if (wrStb || rdStb) begin
            pready_d = 1'b1;
        end
        if (wrStb) begin
            case (paddr)
                `CFGSEQ_CTRL_ADDR: begin
                    ctrl_d = pwdata[12:0];
                    if (pwdata[`CFGSEQ_CTRL_KEY +: 1] == 1'b1) begin
                        ctrl_d[`CFGSEQ_CTRL_KEY] = 1'b1; // index 3
                    end
                end
                `CFGSEQ_PHASE_ADDR: phase_d = pwdata[19:0];
                `CFGSEQ_RATE_ADDR: begin
                    if (pwdata[5:0] >= `CFGSEQ_RATE_MIN && pwdata[5:0] <= `CFGSEQ_RATE_MAX)
                        rate_d = pwdata[5:0];
                    else
                        pslverr_d = 1'b1;
                end
                `CFGSEQ_DEBUG_ADDR: debug_d = pwdata;
                `CFGSEQ_CMD_ADDR: begin
                    if (pwdata[`CFGSEQ_CMD_SHUTDOWN]) shutSeen_d = 1'b1;
                    if (pwdata[`CFGSEQ_CMD_GHIGH]) ghighSeen_d = 1'b1;
                    if (ctrl_q[`CFGSEQ_CTRL_DEBUG] && pwdata[`CFGSEQ_CMD_SYNC])
                        debug_d = {`CFGSEQ_DEBUG_ZERO_BITS{1'b0}};
                    if (pwdata[`CFGSEQ_CMD_FRAME]) begin
                        if (ctrl_q[`CFGSEQ_CTRL_DEBUG] && crcPending_q)
                            pslverr_d = 1'b1;
                        else if (ctrl_q[`CFGSEQ_CTRL_DEBUG]) begin
                            debug_d = pwdata; // frame address logged
                            crcPending_d = 1'b1;
                        end
                    end
                    if (pwdata[`CFGSEQ_CMD_CRC]) crcPending_d = 1'b0;
                    if (pwdata[`CFGSEQ_CMD_MULTI]) multiCount_d = multiCount_q + 8'h01;
                    if (secBlocked && cfgseq_sec_t'(ctrl_q[`CFGSEQ_CTRL_SEC_LO +: 2])
                        == CFGSEQ_SEC_L2 && pwdata[`CFGSEQ_CMD_RECONFIG])
                        pslverr_d = 1'b1;
                end
                default: pslverr_d = 1'b1;
            endcase
        end
        if (rdStb) begin
            case (paddr)
                `CFGSEQ_CTRL_ADDR: prdata_d = {19'h0, ctrl_q};
                `CFGSEQ_PHASE_ADDR: prdata_d = {12'h0, phase_q};
                `CFGSEQ_RATE_ADDR: prdata_d = {26'h0, rate_q};
                `CFGSEQ_STAT_ADDR: prdata_d = {16'h0, multiCount_q, 1'b0, crcPending_q,
                    gwe_q, tri_q, doneAct_q, ph_q};
                `CFGSEQ_DEBUG_ADDR: begin
                    prdata_d = secBlocked ? 32'h0 : debug_q;
                    pslverr_d = secBlocked;
                end
                default: begin
                    prdata_d = 32'h0;
                    pslverr_d = 1'b1;
                end
            endcase
        end
        rbAllow_d = !ctrl_d[`CFGSEQ_CTRL_SEC_LO + 1] && !ctrl_d[`CFGSEQ_CTRL_SEC_LO];
        prAllow_d = !ctrl_d[`CFGSEQ_CTRL_SEC_LO + 1];
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_q <= 13'h0000;
            phase_q <= 20'(`CFGSEQ_PHASE_RST);
            rate_q <= `CFGSEQ_RATE_MIN;
            debug_q <= 32'h00000000;
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            shutSeen_q <= 1'b0;
            ghighSeen_q <= 1'b0;
            cmReset_q <= 1'b0;
            crcPending_q <= 1'b0;
            multiCount_q <= 8'h00;
            rbAllow_q <= 1'b1;
            prAllow_q <= 1'b1;
        end else begin
            ctrl_q <= ctrl_d;
            phase_q <= phase_d;
            rate_q <= rate_d;
            debug_q <= debug_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            shutSeen_q <= shutSeen_d;
            ghighSeen_q <= ghighSeen_d;
            cmReset_q <= cmReset_d;
            crcPending_q <= crcPending_d;
            multiCount_q <= multiCount_d;
            rbAllow_q <= rbAllow_d;
            prAllow_q <= prAllow_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all flip-flop driven
    // ------------------------------------------------------------------------
    cfgseq_out_t outs;
    assign outs = '{gwe_q, gwe_q, holdOut_q, doneAct_q, doneOe_q};
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign globalWriteEnable = outs.globalWriteEnable;
    assign blockMemoryEnable = outs.blockMemoryEnable;
    assign globalTristateHold = outs.globalTristateHold;
    assign donePinOut = outs.doneDrive;
    assign donePinOe = outs.doneOe;
    assign clockManagerReset = cmReset_q;
    assign configPortDedicated = ctrl_q[`CFGSEQ_CTRL_PERSIST];
    assign readbackAllowed = rbAllow_q;
    assign partialReconfigAllowed = prAllow_q;
    assign configClockRate = rate_q;
endmodule : cfgseq_top

// file: bench/cfgseq_props.sv
`timescale 1ns/1ps
module cfgseq_props import cfgseq_pkg::*; (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Startup outputs
    input wire logic globalWriteEnable,
    input wire logic blockMemoryEnable,
    input wire logic globalTristateHold,
    input wire logic donePinOut,
    input wire logic donePinOe,
    input wire logic clockManagerReset,
    input wire logic readbackAllowed,
    input wire logic partialReconfigAllowed,
    input wire logic [5:0] configClockRate
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_APB_ONE_WAIT: assert property ($rose(penable) && psel |=> pready)
        else $error("pready missing one cycle after access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_RESET_VALUES: assert property ($rose(rst_n) |-> globalTristateHold &&
        !globalWriteEnable && !donePinOut && readbackAllowed && configClockRate == 6'h04)
        else $error("wrong output values after reset");
    AST_BME_WITH_GWE: assert property (blockMemoryEnable == globalWriteEnable)
        else $error("block memory enable differs from write enable");
    AST_DRIVE_HIGH: assert property (donePinOe |-> donePinOut)
        else $error("completion pin driven while not complete");
    AST_RATE_LEGAL: assert property (configClockRate inside {[6'h04:6'h3c]})
        else $error("clock rate setting out of range");
    AST_SEC_ORDER: assert property (!partialReconfigAllowed |-> !readbackAllowed)
        else $error("partial reconfig blocked but readback allowed");
    AST_MGR_RESET_PULSE: assert property (clockManagerReset |=> !clockManagerReset)
        else $error("clock manager reset longer than one cycle");
    // A quiet bus for four cycles rules out a restart command in flight.
    AST_TRI_STAYS: assert property ((!psel && !clockManagerReset)[*4] ##0
        !globalTristateHold |=> !globalTristateHold)
        else $error("tri-state hold returned without restart");
    AST_WE_STAYS: assert property ((!psel && !clockManagerReset)[*4] ##0
        globalWriteEnable |=> globalWriteEnable)
        else $error("write enable dropped without restart");
endmodule : cfgseq_props

bind cfgseq_top cfgseq_props u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .globalWriteEnable(globalWriteEnable),
    .blockMemoryEnable(blockMemoryEnable), .globalTristateHold(globalTristateHold),
    .donePinOut(donePinOut), .donePinOe(donePinOe), .clockManagerReset(clockManagerReset),
    .readbackAllowed(readbackAllowed), .partialReconfigAllowed(partialReconfigAllowed),
    .configClockRate(configClockRate)
);

// file: bench/cfgseq_done_chain.sv
`timescale 1ns/1ps
module cfgseq_done_chain import cfgseq_pkg::*; (
    // Completion pin of this device
    input wire logic donePinOut,
    input wire logic donePinOe,
    // Neighbour in the daisy chain still configuring
    input wire logic chainHold,
    output logic donePinIn
);
    // Open-drain wire with pull-up: a busy neighbour keeps it low unless actively driven.
    assign donePinIn = (donePinOe & donePinOut) | (donePinOut & !chainHold);
endmodule : cfgseq_done_chain

// file: bench/cfgseq_bench.sv
`timescale 1ns/1ps
`include "cfgseq_regs.svh"
module cfgseq_bench import cfgseq_pkg::*;;
    logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic locked = 0, matched = 0, chainHold = 0, drv, donePinIn;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, wv;
    logic [2:0] clks = 3'h0;
    logic [3:0] dn, tr, we, lk, mt, p, st;
    logic pready, pslverr, globalWriteEnable, blockMemoryEnable, globalTristateHold;
    logic donePinOut, donePinOe, clockManagerReset, configPortDedicated;
    logic readbackAllowed, partialReconfigAllowed;
    logic [5:0] configClockRate, rate;
    int errors = 0, cmp_count = 0, resetCount = 0, seenBefore;
    wire cfgseq_out_t outs = {globalWriteEnable, blockMemoryEnable, globalTristateHold,
        donePinOut, donePinOe};

    cfgseq_top dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfgClkTick(clks[0]), .userClock(clks[1]), .testPortClock(clks[2]),
        .clockManagerLocked(locked), .impedanceMatched(matched), .donePinIn(donePinIn),
        .globalWriteEnable(globalWriteEnable), .blockMemoryEnable(blockMemoryEnable),
        .globalTristateHold(globalTristateHold), .donePinOut(donePinOut),
        .donePinOe(donePinOe), .clockManagerReset(clockManagerReset),
        .configPortDedicated(configPortDedicated), .readbackAllowed(readbackAllowed),
        .partialReconfigAllowed(partialReconfigAllowed), .configClockRate(configClockRate));
    cfgseq_done_chain far (.donePinOut(donePinOut), .donePinOe(donePinOe),
        .chainHold(chainHold), .donePinIn(donePinIn));

    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (clockManagerReset === 1'b1) resetCount <= resetCount + 1;
    end

    function automatic cfgseq_out_t exp_out(logic [3:0] q, logic [3:0] d, logic [3:0] t,
        logic [3:0] w, logic a);
        return {q >= w, q >= w, q < t, q >= d, a && q >= d};
    endfunction : exp_out

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            errors++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk
    task automatic rst();
        rst_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask : rst
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // An unselected source pulses first, so stepping on the wrong clock shows.
    task automatic step(input int s);
        clks[(s + 1) % 3] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        clks <= 3'h0;
        repeat (4) @(posedge sys_clk);
        clks[s] <= 1'b1;
        repeat (4) @(posedge sys_clk);
        clks <= 3'h0;
        repeat (5) @(posedge sys_clk);
    endtask : step
    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (60000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(9227));
        rst();
        apb(1'b0, `CFGSEQ_PHASE_ADDR, 32'h0);
        chk(rd, `CFGSEQ_PHASE_RST);
        chk({outs, readbackAllowed, configClockRate}, {5'h04, 1'b1, 6'h04});
        for (int it = 0; it < 6; it++) begin
            dn = 4'($urandom_range(6, 1));
            tr = 4'($urandom_range(6, 1));
            we = 4'($urandom_range(6, 1));
            lk = 4'($urandom_range(7, 0));
            mt = 4'($urandom_range(7, 0));
            drv = 1'($urandom_range(1, 0));
            rst();
            locked <= (lk == 4'h7);
            matched <= (mt == 4'h7);
            apb(1'b1, `CFGSEQ_PHASE_ADDR, {12'h0, mt, lk, we, tr, dn});
            apb(1'b1, `CFGSEQ_CTRL_ADDR, 32'h1000 | (it % 3) << 6 | drv << 1);
            p = 4'h0;
            st = 4'h0;
            while (p < 4'h6) begin
                if (st >= 4'h2) locked <= 1'b1;
                if (st >= 4'h2) matched <= 1'b1;
                step(it % 3);
                if ((p == lk && !locked) || (p == mt && !matched)) st++;
                else p++;
                apb(1'b0, `CFGSEQ_STAT_ADDR, 32'h0);
                chk(rd[2:0], p[2:0]);
                chk(outs, exp_out(p, dn, tr, we, drv));
            end
        end
        for (int pp = 0; pp < 2; pp++) begin
            rst();
            chainHold <= 1'b1;
            apb(1'b1, `CFGSEQ_PHASE_ADDR, 32'h00077982);
            apb(1'b1, `CFGSEQ_CTRL_ADDR, 32'h1000 | pp);
            repeat (7) step(0);
            chk(globalTristateHold, 1'b1);
            chainHold <= 1'b0;
            repeat (8) @(posedge sys_clk);
            chk(globalTristateHold, pp);
            step(0);
            chk({globalTristateHold, globalWriteEnable}, 2'h0);
        end
        apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h4);
        chk(outs, 5'h04);
        rate = 6'h04;
        for (int i = 0; i < 6; i++) begin
            wv = i < 4 ? 32'h3c3d0300 >> (8 * i) & 32'hff : $urandom_range(60, 4);
            apb(1'b1, `CFGSEQ_RATE_ADDR, wv);
            chk(err, wv < 4 || wv > 60);
            if (wv >= 4 && wv <= 60) rate = 6'(wv);
            chk(configClockRate, rate);
        end
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, `CFGSEQ_CTRL_ADDR, s << 4 | 32'h4);
            chk({readbackAllowed, partialReconfigAllowed, configPortDedicated},
                {s == 0, s < 2, 1'b1});
        end
        apb(1'b0, 12'h040, 32'h0);
        chk(err, 1'b1);
        // Each pass starts from reset, so command flags left by the last pass cannot fire.
        for (int en = 0; en < 2; en++) begin
            rst();
            apb(1'b1, `CFGSEQ_CTRL_ADDR, en << 3);
            seenBefore = resetCount;
            apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h1);
            apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h2);
            repeat (4) @(posedge sys_clk);
            chk(resetCount - seenBefore, en);
        end
        apb(1'b1, `CFGSEQ_CTRL_ADDR, 32'h0900);
        apb(1'b0, `CFGSEQ_CTRL_ADDR, 32'h0);
        chk(rd, 32'h0900);
        apb(1'b1, `CFGSEQ_DEBUG_ADDR, 32'hffffffff);
        apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h40);
        apb(1'b0, `CFGSEQ_DEBUG_ADDR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h00a50008);
        apb(1'b0, `CFGSEQ_DEBUG_ADDR, 32'h0);
        chk(rd, 32'h00a50008);
        apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h00b60008);
        chk(err, 1'b1);
        apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h10);
        repeat (2) apb(1'b1, `CFGSEQ_CMD_ADDR, 32'h20);
        apb(1'b0, `CFGSEQ_STAT_ADDR, 32'h0);
        chk(rd[15:6], 10'h008);
        apb(1'b1, `CFGSEQ_CTRL_ADDR, 32'h0810);
        apb(1'b0, `CFGSEQ_DEBUG_ADDR, 32'h0);
        chk(rd, 32'h0);
        chk(err, 1'b1);
        tally_and_finish();
    end
endmodule : cfgseq_bench
